/* File: src/ascp_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module ascp_dev
   import ascp_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   ascp_link.dev link,
   input wire logic [CH_N*W-1:0] raw_in,
   output logic [CH_N*W-1:0] sample_out,
   output logic sample_valid
);
   logic [RW-1:0] gain_sel_reg;
   logic [RW-1:0] clk_cfg_reg;
   logic [RW-1:0] dc_cfg_reg;
   logic [RW-1:0] ch_reg [CH_N][NF];
   logic mod_half_reg;
   logic [15:0] mod_cnt_reg;
   logic [W-1:0] raw_hold_reg [CH_N];
   logic [W-1:0] dc_acc_reg [CH_N];
   logic [W-1:0] result_reg [CH_N];
   logic res_valid_reg;
   logic [W-1:0] out_buf_reg [CH_N];
   logic frame_read_reg;
   logic sclk_d_reg;
   logic cs_d_reg;
   logic [FRAME_BITS-1:0] tx_sh_reg;
   logic [W-1:0] rx_sh_reg;
   logic [7:0] bit_cnt_reg;
   logic cmd_strobe_reg;
   logic [W-1:0] cmd_reg;
   logic mod_tick;
   logic period_end;
   logic rise;
   logic fall;
   logic frame_start;
   logic [2:0] osr_code;
   logic [CH_N-1:0] ch_en;
   logic [W-1:0] corr [CH_N];
   logic [W-1:0] dc_out [CH_N];
   logic [FRAME_BITS-1:0] frame_word;

   ////////////////////////////////////////////////////////////////////////
   // Correction arithmetic
   function automatic logic [W-1:0] correct(input logic [W-1:0] raw,
      input logic [GSEL_W-1:0] gsel, input logic [W-1:0] off,
      input logic [W-1:0] gcal);
      logic signed [W-1:0] x;
      logic signed [W-1:0] y;
      logic signed [2*W-1:0] p;
      x = W'(raw << gsel);
      y = x - $signed(off);
      p = y * $signed({1'b0, gcal[W-1:1]});
      correct = p[2*W-3:W-2];
   endfunction

   assign osr_code = clk_cfg_reg[CLK_OSR_LSB +: 3];
   assign ch_en = clk_cfg_reg[CLK_EN_LSB +: CH_N];

   ////////////////////////////////////////////////////////////////////////
   // Modulator clock and ratio counter
   // divide by two
   assign mod_tick = link.conv_clock_in && mod_half_reg;
   assign period_end = mod_tick && (mod_cnt_reg >= osr_len(osr_code) - 16'h0001);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mod_half_reg <= 1'b0;
      end else if (link.conv_clock_in) begin
         mod_half_reg <= ~mod_half_reg;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mod_cnt_reg <= 16'h0000;
      end else if (period_end) begin
         mod_cnt_reg <= 16'h0000;
      end else if (mod_tick) begin
         mod_cnt_reg <= mod_cnt_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         gain_sel_reg <= GAIN_RST;
         clk_cfg_reg <= CLK_RST;
         dc_cfg_reg <= DCBLK_RST;
         for (int c = 0; c < CH_N; c++) begin
            for (int f = 0; f < NF; f++) begin
               ch_reg[c][f] <= (f == F_GCAL_U) ? GCAL_U_RST : ZERO_RST;
            end
         end
      end else if (cmd_strobe_reg && cmd_reg[OP_MSB -: 2] == OP_WRITE) begin
         if (cmd_reg[ADDR_LSB +: AW] == RA_GAIN) begin
            gain_sel_reg <= cmd_reg[RW-1:0];
         end else if (cmd_reg[ADDR_LSB +: AW] == RA_CLK) begin
            clk_cfg_reg <= cmd_reg[RW-1:0];
         end else if (cmd_reg[ADDR_LSB +: AW] == RA_DCBLK) begin
            dc_cfg_reg <= cmd_reg[RW-1:0];
         end else begin
            for (int c = 0; c < CH_N; c++) begin
               for (int f = 0; f < NF; f++) begin
                  if (cmd_reg[ADDR_LSB +: AW] == ch_addr(c, f)) begin
                     ch_reg[c][f] <= cmd_reg[RW-1:0];
                  end
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-channel sampling and correction
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < CH_N; c++) begin
            raw_hold_reg[c] <= '0;
         end
      end else if (mod_tick) begin
         for (int c = 0; c < CH_N; c++) begin
            if (mod_cnt_reg == 16'(ch_reg[c][F_CFG][PH_LSB +: PH_W])) begin
               raw_hold_reg[c] <= (ch_reg[c][F_CFG][MUX_LSB +: 2] == MUX_EXT) ?
                  raw_in[c*W +: W] : '0;
            end
         end
      end
   end

   always_comb begin
      for (int c = 0; c < CH_N; c++) begin
         corr[c] = correct(raw_hold_reg[c],
            gain_sel_reg[c*GSEL_STRIDE +: GSEL_W],
            {ch_reg[c][F_OCAL_U], ch_reg[c][F_OCAL_L][RW-1 -: W-RW]},
            {ch_reg[c][F_GCAL_U], ch_reg[c][F_GCAL_L][RW-1 -: W-RW]});
         dc_out[c] = dc_cfg_reg[c] ? corr[c] - dc_acc_reg[c] : corr[c];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < CH_N; c++) begin
            dc_acc_reg[c] <= '0;
            result_reg[c] <= '0;
         end
      end else if (period_end) begin
         for (int c = 0; c < CH_N; c++) begin
            dc_acc_reg[c] <= dc_acc_reg[c] + W'($signed(dc_out[c]) >>> DC_SHIFT);
            result_reg[c] <= ch_en[c] ? dc_out[c] : '0;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         res_valid_reg <= 1'b0;
      end else begin
         res_valid_reg <= period_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output buffer and ready line
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < CH_N; c++) begin
            out_buf_reg[c] <= '0;
         end
         sample_valid <= 1'b0;
      end else begin
         sample_valid <= 1'b0;
         if (res_valid_reg && frame_read_reg) begin
            for (int c = 0; c < CH_N; c++) begin
               out_buf_reg[c] <= result_reg[c];
            end
            sample_valid <= 1'b1;
         end
      end
   end

   always_comb begin
      for (int c = 0; c < CH_N; c++) begin
         sample_out[c*W +: W] = out_buf_reg[c];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         frame_read_reg <= 1'b1;
         link.sample_ready_n <= 1'b1;
      end else if (res_valid_reg && frame_read_reg) begin
         frame_read_reg <= 1'b0;
         link.sample_ready_n <= 1'b0;
      end else if (fall && bit_cnt_reg == LAST_BIT) begin
         frame_read_reg <= 1'b1;
         link.sample_ready_n <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial port
   assign rise = link.sclk && !sclk_d_reg && !link.cs_n;
   assign fall = !link.sclk && sclk_d_reg && !link.cs_n;
   assign frame_start = !link.cs_n && cs_d_reg;

   always_comb begin
      frame_word = '0;
      frame_word[FRAME_BITS-1 -: W] = W'(ch_en);
      for (int c = 0; c < CH_N; c++) begin
         frame_word[FRAME_BITS-1-(c+1)*W -: W] = out_buf_reg[c];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclk_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
         link.miso_oe_n <= 1'b1;
      end else begin
         sclk_d_reg <= link.sclk;
         cs_d_reg <= link.cs_n;
         link.miso_oe_n <= link.cs_n;
      end
   end

   // shift on rise, capture on fall
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_sh_reg <= '0;
         link.miso_out <= 1'b0;
      end else if (frame_start) begin
         tx_sh_reg <= frame_word;
         link.miso_out <= 1'b0;
      end else if (rise) begin
         link.miso_out <= tx_sh_reg[FRAME_BITS-1];
         tx_sh_reg <= {tx_sh_reg[FRAME_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rx_sh_reg <= '0;
         bit_cnt_reg <= 8'h00;
         cmd_strobe_reg <= 1'b0;
         cmd_reg <= '0;
      end else begin
         cmd_strobe_reg <= 1'b0;
         if (frame_start) begin
            bit_cnt_reg <= 8'h00;
         end else if (fall) begin
            rx_sh_reg <= {rx_sh_reg[W-2:0], link.mosi};
            bit_cnt_reg <= bit_cnt_reg + 8'h01;
            if (bit_cnt_reg == CMD_LAST_BIT) begin
               cmd_reg <= {rx_sh_reg[W-2:0], link.mosi};
               cmd_strobe_reg <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/ascp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ascp_host
   import ascp_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   ascp_link.host link,
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   output logic irq
);
   localparam logic [3:0] HA_CTRL = 4'h0;
   localparam logic [3:0] HA_CMD = 4'h1;
   localparam logic [3:0] HA_STAT = 4'h2;
   localparam logic [3:0] HA_MASK = 4'h3;
   localparam logic [3:0] HA_SEEN = 4'h4;
   localparam logic [3:0] HA_CH0 = 4'h8;
   localparam int CMD_W = AW + RW;

   typedef enum logic [2:0] {
      H_IDLE = 3'b001,
      H_XFER = 3'b010,
      H_END = 3'b100
   } ascp_hst_e;

   ascp_hst_e state_reg;
   logic [7:0] conv_cnt_reg;
   logic [7:0] half_cnt_reg;
   logic serve_reg;
   logic [CMD_W-1:0] cmd_reg;
   logic cmd_pend_reg;
   logic is_cmd_reg;
   logic data_pend_reg;
   logic rdy_d_reg;
   logic [1:0] status_reg;
   logic [1:0] mask_reg;
   logic [2:0] seen_reg;
   logic [W-1:0] ch_data_reg [CH_N];
   logic [FRAME_BITS-1:0] tx_reg;
   logic [FRAME_BITS-1:0] rx_reg;
   logic [7:0] bit_cnt_reg;
   logic half_tick;
   logic start_cmd;
   logic start_data;
   logic done;
   logic [AW-1:0] sent_addr_reg;

   assign half_tick = half_cnt_reg == SCLK_HALF_M1;
   assign start_cmd = state_reg == H_IDLE && cmd_pend_reg;
   assign start_data = state_reg == H_IDLE && !cmd_pend_reg && data_pend_reg
      && serve_reg && (&seen_reg);
   assign done = state_reg == H_END && half_tick;

   // Address of the command frame in flight
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sent_addr_reg <= '0;
      end else if (start_cmd) begin
         sent_addr_reg <= cmd_reg[CMD_W-1 -: AW];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion clock enable
   // conversion clock rate
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         conv_cnt_reg <= 8'h00;
         link.conv_clock_in <= 1'b0;
      end else begin
         link.conv_clock_in <= conv_cnt_reg == CONV_DIV_M1;
         conv_cnt_reg <= (conv_cnt_reg == CONV_DIV_M1) ? 8'h00 : conv_cnt_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         serve_reg <= 1'b0;
         mask_reg <= 2'h0;
         cmd_reg <= '0;
      end else if (sw_wr) begin
         if (sw_addr == HA_CTRL) begin
            serve_reg <= sw_wdata[0];
         end else if (sw_addr == HA_MASK) begin
            mask_reg <= sw_wdata[1:0];
         end else if (sw_addr == HA_CMD && !cmd_pend_reg) begin
            cmd_reg <= sw_wdata[CMD_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmd_pend_reg <= 1'b0;
      end else if (sw_wr && sw_addr == HA_CMD && !cmd_pend_reg) begin
         cmd_pend_reg <= 1'b1;
      end else if (start_cmd) begin
         cmd_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         status_reg <= 2'h0;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (done && (is_cmd_reg == (b == 1))) begin
               status_reg[b] <= 1'b1;
            end else if (sw_wr && sw_addr == HA_STAT && sw_wdata[b]) begin
               status_reg[b] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_reg & mask_reg);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sw_rdata <= 32'h0000_0000;
      end else if (sw_rd) begin
         if (sw_addr == HA_CTRL) begin
            sw_rdata <= {31'h0000_0000, serve_reg};
         end else if (sw_addr == HA_CMD) begin
            sw_rdata <= {9'h000, cmd_pend_reg, cmd_reg};
         end else if (sw_addr == HA_STAT) begin
            sw_rdata <= {30'h0000_0000, status_reg};
         end else if (sw_addr == HA_MASK) begin
            sw_rdata <= {30'h0000_0000, mask_reg};
         end else if (sw_addr == HA_SEEN) begin
            sw_rdata <= {29'h0000_0000, seen_reg};
         end else if (sw_addr >= HA_CH0 && sw_addr < HA_CH0 + 4'(CH_N)) begin
            sw_rdata <= {8'h00, ch_data_reg[2'(sw_addr - HA_CH0)]};
         end else begin
            sw_rdata <= 32'h0000_0000;
         end
      end else begin
         sw_rdata <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration tracking
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         seen_reg <= 3'h0;
      end else if (done && is_cmd_reg) begin
         if (sent_addr_reg == RA_GAIN) begin
            seen_reg[0] <= 1'b1;
         end else if (sent_addr_reg == RA_CLK) begin
            seen_reg[2] <= 1'b1;
         end else begin
            for (int c = 0; c < CH_N; c++) begin
               if (sent_addr_reg == ch_addr(c, F_CFG)) begin
                  seen_reg[1] <= 1'b1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ready edge detect
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdy_d_reg <= 1'b1;
         data_pend_reg <= 1'b0;
      end else begin
         rdy_d_reg <= link.sample_ready_n;
         if (rdy_d_reg && !link.sample_ready_n) begin
            data_pend_reg <= 1'b1;
         end else if (start_data) begin
            data_pend_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame engine
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= H_IDLE;
         half_cnt_reg <= 8'h00;
         bit_cnt_reg <= 8'h00;
         is_cmd_reg <= 1'b0;
         tx_reg <= '0;
         rx_reg <= '0;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         link.mosi <= 1'b0;
      end else begin
         half_cnt_reg <= half_tick ? 8'h00 : half_cnt_reg + 8'h01;
         case (state_reg)
            H_IDLE: begin
               if (start_cmd || start_data) begin
                  state_reg <= H_XFER;
                  is_cmd_reg <= start_cmd;
                  tx_reg <= {start_cmd ? OP_WRITE : 2'h0, cmd_reg,
                     {(FRAME_BITS-W){1'b0}}};
                  bit_cnt_reg <= 8'h00;
                  half_cnt_reg <= 8'h00;
                  link.cs_n <= 1'b0;
               end
            end
            H_XFER: begin
               if (half_tick) begin
                  if (!link.sclk) begin
                     link.sclk <= 1'b1;
                     link.mosi <= tx_reg[FRAME_BITS-1];
                     tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
                  end else begin
                     link.sclk <= 1'b0;
                     rx_reg <= {rx_reg[FRAME_BITS-2:0], link.miso};
                     bit_cnt_reg <= bit_cnt_reg + 8'h01;
                     if (bit_cnt_reg == LAST_BIT) begin
                        state_reg <= H_END;
                     end
                  end
               end
            end
            H_END: begin
               link.mosi <= 1'b0;
               if (half_tick) begin
                  link.cs_n <= 1'b1;
                  state_reg <= H_IDLE;
               end
            end
            default: begin
               state_reg <= H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < CH_N; c++) begin
            ch_data_reg[c] <= '0;
         end
      end else if (done && !is_cmd_reg) begin
         for (int c = 0; c < CH_N; c++) begin
            ch_data_reg[c] <= rx_reg[FRAME_BITS-1-(c+1)*W -: W];
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/ascp_link.sv */
`timescale 1ns/1ps
`default_nettype none
interface ascp_link;
   logic conv_clock_in;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso_out;
   logic miso_oe_n;
   logic miso;
   logic sample_ready_n;
   // Undriven line reads low
   assign miso = miso_oe_n ? 1'b0 : miso_out;
   modport dev (input conv_clock_in, input sclk, input cs_n, input mosi,
      output miso_out, output miso_oe_n, output sample_ready_n);
   modport host (output conv_clock_in, output sclk, output cs_n, output mosi,
      input miso, input sample_ready_n);
endinterface
`default_nettype wire

/* File: src/ascp_pkg.sv */
package ascp_pkg;
   localparam int CH_N = 4;
   localparam int W = 24;
   localparam int RW = 16;
   localparam int AW = 6;
   localparam int FRAME_WORDS = CH_N + 1;
   localparam int FRAME_BITS = FRAME_WORDS * W;
   localparam logic [7:0] LAST_BIT = 8'(FRAME_BITS - 1);
   localparam logic [7:0] CMD_LAST_BIT = 8'(W - 1);
   // Rates in kHz
   localparam int MCLK_KHZ = 250000;
   localparam int CONV_KHZ = 8192;
   localparam int SCLK_KHZ = 8192;
   localparam int CONV_DIV = MCLK_KHZ / CONV_KHZ;
   localparam int SCLK_HALF = MCLK_KHZ / (2 * SCLK_KHZ);
   localparam logic [7:0] CONV_DIV_M1 = 8'(CONV_DIV - 1);
   localparam logic [7:0] SCLK_HALF_M1 = 8'(SCLK_HALF - 1);
   // Command word
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam int OP_MSB = 23;
   localparam int ADDR_LSB = 16;
   // Device register addresses
   localparam logic [AW-1:0] RA_DCBLK = 6'h02;
   localparam logic [AW-1:0] RA_CLK = 6'h03;
   localparam logic [AW-1:0] RA_GAIN = 6'h04;
   localparam int RA_CH0 = 8;
   localparam int RA_STRIDE = 8;
   localparam int NF = 5;
   localparam int F_CFG = 0;
   localparam int F_OCAL_U = 1;
   localparam int F_OCAL_L = 2;
   localparam int F_GCAL_U = 3;
   localparam int F_GCAL_L = 4;
   // Fields
   localparam int CLK_EN_LSB = 8;
   localparam int CLK_OSR_LSB = 2;
   localparam int CLK_PWR_LSB = 0;
   localparam logic [1:0] PWR_HIGH_RES = 2'h2;
   localparam int PH_LSB = 6;
   localparam int PH_W = 10;
   localparam int MUX_LSB = 0;
   localparam logic [1:0] MUX_EXT = 2'h0;
   localparam int GSEL_W = 3;
   localparam int GSEL_STRIDE = 4;
   localparam int DC_SHIFT = 6;
   localparam int OSR_BASE = 128;
   // Reset values
   localparam logic [RW-1:0] CLK_RST = 16'h0F0A;
   localparam logic [RW-1:0] GAIN_RST = 16'h0000;
   localparam logic [RW-1:0] DCBLK_RST = 16'h0000;
   localparam logic [RW-1:0] GCAL_U_RST = 16'h8000;
   localparam logic [RW-1:0] ZERO_RST = 16'h0000;

   function automatic logic [AW-1:0] ch_addr(input int c, input int f);
      ch_addr = AW'(RA_CH0 + c * RA_STRIDE + f);
   endfunction

   function automatic logic [15:0] osr_len(input logic [2:0] code);
      osr_len = 16'(OSR_BASE) << code;
   endfunction
endpackage

/* File: test/adc_sample_calibration_path_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_sample_calibration_path_tb
   import ascp_pkg::*;
;
   typedef struct packed {
      logic [23:0] raw;
      logic [15:0] off;
      logic [15:0] gc;
      logic [23:0] res;
   } ascp_row_s;
   ascp_row_s rows [CH_N];
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [31:0] sw_rdata;
   logic irq;
   logic [CH_N*W-1:0] raw_in = '0;
   logic [CH_N*W-1:0] sample_out;
   logic sample_valid;
   logic [31:0] d;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int t0;
   ascp_link i_ascp_link();
   ascp_dev i_ascp_dev(.mclk(mclk), .resetn(resetn), .link(i_ascp_link), .raw_in(raw_in),
      .sample_out(sample_out), .sample_valid(sample_valid));
   ascp_host i_ascp_host(.mclk(mclk), .resetn(resetn), .link(i_ascp_link), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
   ascp_checker i_ascp_checker(.mclk(mclk), .resetn(resetn),
      .conv_clock_in(i_ascp_link.conv_clock_in), .sclk(i_ascp_link.sclk),
      .cs_n(i_ascp_link.cs_n), .mosi(i_ascp_link.mosi), .miso_oe_n(i_ascp_link.miso_oe_n),
      .sample_ready_n(i_ascp_link.sample_ready_n));
   always #2 mclk = ~mclk;
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 97000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", s, e, g);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      sw_addr <= a;
      sw_wdata <= v;
      sw_wr <= 1'b1;
      @(posedge mclk);
      sw_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge mclk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge mclk);
      sw_rd <= 1'b0;
      #1 v = sw_rdata;
   endtask
   // Device write through the host, then wait for the frame to start
   task automatic cmd(input logic [5:0] a, input logic [15:0] v);
      wr(4'h1, {10'h000, a, v});
      d = 32'h0040_0000;
      for (int i = 0; i < 2500 && d[22]; i++) rd(4'h1, d);
      chk("pending", 32'h0, 32'(d[22]));
   endtask
   task automatic wait_hi(input logic use_irq);
      do begin
         @(posedge mclk);
         #1;
      end while ((use_irq ? irq : sample_valid) !== 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rows[0] = '{24'h001000, 16'h0000, 16'h8000, 24'h001000};
      rows[1] = '{24'h001000, 16'h0001, 16'h8000, 24'h000F00};
      rows[2] = '{24'h001000, 16'h0000, 16'h4000, 24'h000800};
      rows[3] = '{24'h000100, 16'h0010, 16'h4000, 24'hFFF900};
      for (int c = 0; c < CH_N; c++) raw_in[c*W +: W] = rows[c].raw;
      repeat (8) @(posedge mclk);
      #1;
      chk("idle", 32'hA, {28'h0, i_ascp_link.cs_n, i_ascp_link.sclk,
         i_ascp_link.sample_ready_n, irq});
      @(posedge mclk);
      resetn <= 1'b1;
      wr(4'h3, 32'h1);
      cmd(RA_CLK, CLK_RST);
      cmd(RA_GAIN, 16'h1000);
      for (int c = 0; c < CH_N; c++) begin
         cmd(6'(8 + 8 * c), 16'h0000);
         cmd(6'(9 + 8 * c), rows[c].off);
         cmd(6'(11 + 8 * c), rows[c].gc);
      end
      rd(4'h4, d);
      chk("seen", 32'h7, d);
      chk("masked irq", 32'h0, 32'(irq));
      rd(4'h5, d);
      chk("unmapped", 32'h0, d);
      wr(4'h0, 32'h1);
      wait_hi(1'b0);
      t0 = cyc;
      for (int c = 0; c < CH_N; c++) begin
         chk("out", 32'(rows[c].res), 32'(sample_out[c*W +: W]));
      end
      wr(4'h2, 32'h1);
      wait_hi(1'b1);
      rd(4'h2, d);
      chk("status", 32'h1, d & 32'h1);
      for (int c = 0; c < CH_N; c++) begin
         rd(4'(8 + c), d);
         chk("data", 32'(rows[c].res), 32'(d[23:0]));
      end
      wr(4'h2, 32'h1);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq clear", 32'h0, 32'(irq));
      wait_hi(1'b0);
      chk("period", 32'h7800, 32'(cyc - t0));
      give_verdict();
   end
endmodule
`default_nettype wire

/* File: test/ascp_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ascp_checker (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic conv_clock_in,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso_oe_n,
   input wire logic sample_ready_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic sclk_reg;
   logic [7:0] rise_reg;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) sclk_reg <= 1'b0;
      else sclk_reg <= sclk;
   end
   // Serial clock rises within the frame
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) rise_reg <= 8'h00;
      else if (cs_n) rise_reg <= 8'h00;
      else if (sclk && !sclk_reg) rise_reg <= rise_reg + 8'h01;
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_conv;
      $rose(conv_clock_in) |=> !conv_clock_in ##29 conv_clock_in;
   endproperty
   a_conv: assert property (p_conv) else $error("conv spacing");
   property p_idle;
      cs_n |-> !sclk;
   endproperty
   a_idle: assert property (p_idle) else $error("sclk idle");
   property p_mosi;
      !cs_n && $past(!cs_n) && $changed(mosi) |-> $rose(sclk);
   endproperty
   a_mosi: assert property (p_mosi) else $error("mosi edge");
   property p_half;
      $rose(sclk) |-> ##15 $fell(sclk);
   endproperty
   a_half: assert property (p_half) else $error("sclk half");
   property p_frame;
      $rose(cs_n) |-> rise_reg == 8'h78;
   endproperty
   a_frame: assert property (p_frame) else $error("frame length");
   property p_oe;
      $fell(cs_n) |=> $fell(miso_oe_n) ##1 !miso_oe_n;
   endproperty
   a_oe: assert property (p_oe) else $error("miso enable");
   property p_hold;
      $fell(sample_ready_n) |=> !sample_ready_n [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("ready hold");
   property p_rel;
      $rose(sample_ready_n) |-> !cs_n && rise_reg == 8'h78;
   endproperty
   a_rel: assert property (p_rel) else $error("ready release");
   c_data: cover property ($rose(cs_n) && rise_reg == 8'h78);
   c_cmd: cover property ($fell(cs_n) && sample_ready_n);
   c_ready: cover property ($fell(sample_ready_n));
endmodule
`default_nettype wire
